// *** design/fdm_pkg.sv ***
// Purpose: shared constants for the level alarm dwell timer and signal monitor
// Assumes: byte-wide register port, 16-bit address
// Notes:   offsets are byte addresses of 8-bit registers
package fdm_pkg;
  localparam int          ADDR_W           = 16;
  localparam int          DATA_W           = 8;
  localparam int          MAG_W            = 13;
  localparam int          DWELL_W          = 16;
  localparam int          PERIOD_W         = 24;
  // threshold, dwell, sync and monitor registers (neighbouring map)
  localparam logic [15:0] ADDR_UP_LOW      = 16'h0247;
  localparam logic [15:0] ADDR_UP_HIGH     = 16'h0248;
  localparam logic [15:0] ADDR_LO_LOW      = 16'h0249;
  localparam logic [15:0] ADDR_LO_HIGH     = 16'h024A;
  localparam logic [15:0] ADDR_DWELL_LOW   = 16'h024B;
  localparam logic [15:0] ADDR_DWELL_HIGH  = 16'h024C;
  localparam logic [15:0] ADDR_SYNC_CTRL   = 16'h026F;
  localparam logic [15:0] ADDR_MON_CTRL    = 16'h0270;
  localparam logic [15:0] ADDR_PERIOD_B0   = 16'h0271;
  localparam logic [15:0] ADDR_PERIOD_B1   = 16'h0272;
  localparam logic [15:0] ADDR_PERIOD_B2   = 16'h0273;
  // own registers: peak result, interrupt status and mask
  localparam logic [15:0] ADDR_PEAK_LOW    = 16'h0280;
  localparam logic [15:0] ADDR_PEAK_HIGH   = 16'h0281;
  localparam logic [15:0] ADDR_IRQ_STATUS  = 16'h0282;
  localparam logic [15:0] ADDR_IRQ_MASK    = 16'h0283;
  // field positions
  localparam int          SYNC_EN_BIT      = 0;
  localparam int          SYNC_NEXT_BIT    = 1;
  localparam int          PEAK_EN_BIT      = 1;
  localparam int          IRQ_ALARM_BIT    = 0;
  localparam int          IRQ_RELEASE_BIT  = 1;
  localparam int          IRQ_PERIOD_BIT   = 2;
  localparam int          IRQ_SYNC_BIT     = 3;
  localparam int          IRQ_W            = 4;
  // reset values
  localparam logic [7:0]  RST_PERIOD_B0    = 8'h80;
  localparam logic [7:0]  RST_ZERO         = 8'h00;
endpackage

// *** design/fdm_sync2.sv ***
// Purpose: two-flop synchroniser for one pin level
// Assumes: single clock mclk, synchronous active-high reset
// Notes:   the first flop feeds only the second
`timescale 1ns/1ps
module fdm_sync2 (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic meta;
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // fdm_sync2

// *** design/fdm_byte_reg.sv ***
// Purpose: one byte-wide software register with reset value
// Assumes: write strobe already decoded to this address
// Notes:   reset value is a parameter so each instance keeps its own
`timescale 1ns/1ps
module fdm_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end
endmodule // fdm_byte_reg

// *** design/fdm_top.sv ***
// Purpose: level alarm dwell timer and signal monitor peak detector of one channel
// Assumes: samples arrive as magnitudes on mclk; sysref is an asynchronous pin
// Notes:   byte register port, read data one cycle after the read strobe
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module fdm_top
  import fdm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              sample_valid,
  input  wire logic [MAG_W-1:0]  sample_mag,
  input  wire logic              sysref,
  output logic                   level_alarm_outputs,
  output logic                   irq
);
  // register write decode
  logic                wr_up_l, wr_up_h, wr_lo_l, wr_lo_h;
  logic                wr_dw_l, wr_dw_h, wr_sync, wr_mctl;
  logic                wr_p0, wr_p1, wr_p2, wr_ists, wr_imsk;
  assign wr_up_l = reg_wr && (reg_addr == ADDR_UP_LOW);
  assign wr_up_h = reg_wr && (reg_addr == ADDR_UP_HIGH);
  assign wr_lo_l = reg_wr && (reg_addr == ADDR_LO_LOW);
  assign wr_lo_h = reg_wr && (reg_addr == ADDR_LO_HIGH);
  assign wr_dw_l = reg_wr && (reg_addr == ADDR_DWELL_LOW);
  assign wr_dw_h = reg_wr && (reg_addr == ADDR_DWELL_HIGH);
  assign wr_sync = reg_wr && (reg_addr == ADDR_SYNC_CTRL);
  assign wr_mctl = reg_wr && (reg_addr == ADDR_MON_CTRL);
  assign wr_p0   = reg_wr && (reg_addr == ADDR_PERIOD_B0);
  assign wr_p1   = reg_wr && (reg_addr == ADDR_PERIOD_B1);
  assign wr_p2   = reg_wr && (reg_addr == ADDR_PERIOD_B2);
  assign wr_ists = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
  assign wr_imsk = reg_wr && (reg_addr == ADDR_IRQ_MASK);

  logic [7:0] up_l, up_h, lo_l, lo_h, dw_l, dw_h, per0, per1, per2;

  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_up_l (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_up_l),
    .wr_data (reg_wdata),
    .q       (up_l)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_up_h (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_up_h),
    .wr_data (reg_wdata),
    .q       (up_h)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_lo_l (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_lo_l),
    .wr_data (reg_wdata),
    .q       (lo_l)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_lo_h (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_lo_h),
    .wr_data (reg_wdata),
    .q       (lo_h)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_dw_l (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_dw_l),
    .wr_data (reg_wdata),
    .q       (dw_l)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_dw_h (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_dw_h),
    .wr_data (reg_wdata),
    .q       (dw_h)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_PERIOD_B0)
  ) u_per0 (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_p0),
    .wr_data (reg_wdata),
    .q       (per0)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_per1 (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_p1),
    .wr_data (reg_wdata),
    .q       (per1)
  );
  fdm_byte_reg #(
    .RESET_VAL (RST_ZERO)
  ) u_per2 (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_p2),
    .wr_data (reg_wdata),
    .q       (per2)
  );

  // thresholds keep only their 13 significant bits
  logic [MAG_W-1:0]    thr_upper;
  logic [MAG_W-1:0]    thr_lower;
  logic [DWELL_W-1:0]  dwell_target;
  logic [PERIOD_W-1:0] period;
  assign thr_upper    = {up_h[4:0], up_l};
  assign thr_lower    = {lo_h[4:0], lo_l};
  assign dwell_target = {dw_h, dw_l};
  assign period       = {per2, per1, per0};

  // control bits
  logic sync_en;
  logic sync_next;
  logic peak_en;
  logic sync_hit;

  // sysref pin: synchronise, then detect rising edge
  logic sysref_s;
  logic sysref_d;
  logic sysref_rise;
  fdm_sync2 u_sysref_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (sysref),
    .dout  (sysref_s)
  );
  assign sysref_rise = sysref_s && !sysref_d;
  // disabled sync means edges never realign
  assign sync_hit    = sysref_rise && sync_en;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sysref_d  <= 1'b0;
      sync_en   <= 1'b0;
      sync_next <= 1'b0;
      peak_en   <= 1'b0;
    end else begin
      sysref_d <= sysref_s;
      if (wr_mctl) begin
        peak_en <= reg_wdata[PEAK_EN_BIT];
      end
      if (wr_sync) begin
        sync_next <= reg_wdata[SYNC_NEXT_BIT];
      end
      // hardware clear wins only when no write lands in the same cycle
      if (wr_sync) begin
        sync_en <= reg_wdata[SYNC_EN_BIT];
      end else if (sync_hit && sync_next) begin
        sync_en <= 1'b0;
      end
    end
  end

  // level alarm: set above upper, released after dwell below lower
  logic               mag_above_upper;
  logic               mag_below_lower;
  logic [DWELL_W-1:0] dwell_cnt;
  logic               dwell_done;
  logic               alarm_set_ev;
  logic               alarm_clr_ev;
  assign mag_above_upper = sample_mag > thr_upper;
  assign mag_below_lower = sample_mag < thr_lower;
  assign dwell_done      = (dwell_cnt >= dwell_target);
  assign alarm_set_ev    = sample_valid && mag_above_upper && !level_alarm_outputs;
  assign alarm_clr_ev    = sample_valid && level_alarm_outputs && !mag_above_upper
                           && mag_below_lower && dwell_done;

  always_ff @(posedge mclk) begin
    if (reset) begin
      level_alarm_outputs <= 1'b0;
      dwell_cnt           <= '0;
    end else if (sample_valid) begin
      if (mag_above_upper) begin
        level_alarm_outputs <= 1'b1;
        dwell_cnt           <= '0;
      end else if (!mag_below_lower) begin
        dwell_cnt <= '0;
      end else if (level_alarm_outputs) begin
        if (alarm_clr_ev) begin
          level_alarm_outputs <= 1'b0;
          dwell_cnt           <= '0;
        end else begin
          dwell_cnt <= dwell_cnt + 16'h0001;
        end
      end
    end
  end

  // signal monitor: period counter and peak detector
  // a period lasts exactly that many mclk cycles, odd or even; zero expires every cycle
  logic [PERIOD_W-1:0] per_cnt;
  logic                per_expire;
  logic [MAG_W-1:0]    peak_run;
  logic [MAG_W-1:0]    peak_result;
  assign per_expire = (per_cnt >= period - 24'h000001) || (period == '0);

  always_ff @(posedge mclk) begin
    if (reset) begin
      per_cnt     <= '0;
      peak_run    <= '0;
      peak_result <= '0;
    end else if (sync_hit || !peak_en) begin
      per_cnt  <= '0;
      peak_run <= '0;
    end else if (per_expire) begin
      per_cnt     <= '0;
      peak_result <= peak_run;
      peak_run    <= (sample_valid) ? sample_mag : '0;
    end else begin
      per_cnt <= per_cnt + 24'h000001;
      if (sample_valid && sample_mag > peak_run) begin
        peak_run <= sample_mag;
      end
    end
  end

  // interrupts: sticky status, write one to clear, set wins
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;
  assign irq_events[IRQ_ALARM_BIT]   = alarm_set_ev;
  assign irq_events[IRQ_RELEASE_BIT] = alarm_clr_ev;
  assign irq_events[IRQ_PERIOD_BIT]  = peak_en && per_expire && !sync_hit;
  assign irq_events[IRQ_SYNC_BIT]    = sync_hit;
  assign irq_clear = wr_ists ? reg_wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (wr_imsk) begin
        irq_mask <= reg_wdata[IRQ_W-1:0];
      end
      irq <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
    end
  end

  // read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == ADDR_UP_LOW)     ? up_l :
    (reg_addr == ADDR_UP_HIGH)    ? {3'b000, up_h[4:0]} :
    (reg_addr == ADDR_LO_LOW)     ? lo_l :
    (reg_addr == ADDR_LO_HIGH)    ? {3'b000, lo_h[4:0]} :
    (reg_addr == ADDR_DWELL_LOW)  ? dw_l :
    (reg_addr == ADDR_DWELL_HIGH) ? dw_h :
    (reg_addr == ADDR_SYNC_CTRL)  ? {6'b000000, sync_next, sync_en} :
    (reg_addr == ADDR_MON_CTRL)   ? {6'b000000, peak_en, 1'b0} :
    (reg_addr == ADDR_PERIOD_B0)  ? per0 :
    (reg_addr == ADDR_PERIOD_B1)  ? per1 :
    (reg_addr == ADDR_PERIOD_B2)  ? per2 :
    (reg_addr == ADDR_PEAK_LOW)   ? peak_result[7:0] :
    (reg_addr == ADDR_PEAK_HIGH)  ? {3'b000, peak_result[12:8]} :
    (reg_addr == ADDR_IRQ_STATUS) ? {4'h0, irq_status} :
    (reg_addr == ADDR_IRQ_MASK)   ? {4'h0, irq_mask} :
    8'h00;

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // fdm_top

// *** sim/fdm_properties.sv ***
// Purpose: port-level checker for fdm_top
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every fdm_top instance
`timescale 1ns/1ps
module fdm_properties
  import fdm_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              sample_valid,
  input wire logic [MAG_W-1:0]  sample_mag,
  input wire logic              sysref,
  input wire logic              level_alarm_outputs,
  input wire logic              irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rd_sync;
    reg_rd && reg_addr == ADDR_SYNC_CTRL;
  endsequence
  sequence s_rd_mon;
    reg_rd && reg_addr == ADDR_MON_CTRL;
  endsequence
  // mask cleared, then irq must drop once the registered path has caught up
  sequence s_mask_off;
    reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata == 8'h00;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_sync_reserved: assert property (s_rd_sync |=> reg_rdata[7:2] == 6'h00)
    else $error("sync control reserved bits set");
  a_mon_reserved: assert property (s_rd_mon |=> !reg_rdata[0]
    && reg_rdata[7:2] == 6'h00)
    else $error("monitor control reserved bits set");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h0000 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_alarm_rise: assert property ($rose(level_alarm_outputs) |-> $past(sample_valid)
    && $past(sample_mag) != 13'h0000)
    else $error("alarm set without a large valid sample");
  a_alarm_fall: assert property ($fell(level_alarm_outputs) |-> $past(sample_valid))
    else $error("alarm released without a valid sample");
  a_alarm_hold: assert property (!sample_valid |=> $stable(level_alarm_outputs))
    else $error("alarm moved on an invalid sample");
  a_irq_masked: assert property (s_mask_off |-> ##2 !irq)
    else $error("irq high with mask cleared");
endmodule // fdm_properties

bind fdm_top fdm_properties fdm_properties_i (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .sample_mag(sample_mag), .sysref(sysref),
  .level_alarm_outputs(level_alarm_outputs), .irq(irq)
);

// *** sim/fdm_sysref_src.sv ***
// Purpose: timing source model driving the sysref pin
// Assumes: pulses only on request, so spacing is chosen by the host
// Notes:   pin rests low between pulses
`timescale 1ns/1ps
module fdm_sysref_src (
  input  wire logic mclk,
  input  wire logic fire,
  output logic      sysref
);
  logic [2:0] left = 3'h0;
  // pulse held four cycles so the two-flop synchroniser cannot miss it
  always_ff @(posedge mclk) begin
    if (fire) begin
      left <= 3'h4;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end
  assign sysref = (left != 3'h0);
endmodule // fdm_sysref_src

// *** sim/tb.sv ***
// Purpose: self-checking bench for fdm_top
// Assumes: 40 MHz mclk, synchronous reset
// Notes:   sysref comes from the partner model
`timescale 1ns/1ps
module tb;
  import fdm_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        sample_valid = 1'b0;
  logic [12:0] sample_mag = 13'h0000;
  logic        sysref;
  logic        fire = 1'b0;
  logic        alarm;
  logic        irq;
  int          bad_count = 0;
  int          tests_run = 0;
  always #12.5 mclk = ~mclk;
  fdm_top fdm_top_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_mag(sample_mag), .sysref(sysref),
    .level_alarm_outputs(alarm), .irq(irq));
  fdm_sysref_src fdm_sysref_src_i (.mclk(mclk), .fire(fire), .sysref(sysref));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
    @(posedge mclk);
  endtask
  task automatic smp(input logic [12:0] m, input int n);
    sample_valid <= 1'b1;
    sample_mag   <= m;
    repeat (n) @(posedge mclk);
  endtask
  // invalid cycle between bursts: the dwell count must hold across it
  task automatic hold(input logic exp);
    sample_valid <= 1'b0;
    #1 chk("alarm", {7'h00, alarm}, {7'h00, exp});
    @(posedge mclk);
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(ADDR_DWELL_LOW, 8'h00, "dwell_low");
    rd(ADDR_DWELL_HIGH, 8'h00, "dwell_high");
    rd(ADDR_SYNC_CTRL, 8'h00, "sync_ctrl");
    rd(ADDR_MON_CTRL, 8'h00, "mon_ctrl");
    rd(ADDR_PERIOD_B0, 8'h80, "period_b0");
    rd(ADDR_PERIOD_B1, 8'h00, "period_b1");
    rd(ADDR_PERIOD_B2, 8'h00, "period_b2");
    rd(16'h0000, 8'h00, "unmapped");
    wr(ADDR_MON_CTRL, 8'hFF);
    rd(ADDR_MON_CTRL, 8'h02, "mon_ctrl");
    wr(ADDR_MON_CTRL, 8'h00);
    wr(ADDR_PERIOD_B1, 8'hA5);
    rd(ADDR_PERIOD_B1, 8'hA5, "period_b1");
    wr(ADDR_PERIOD_B2, 8'h5A);
    rd(ADDR_PERIOD_B2, 8'h5A, "period_b2");
    wr(ADDR_DWELL_HIGH, 8'hC3);
    rd(ADDR_DWELL_HIGH, 8'hC3, "dwell_high");
    wr(ADDR_DWELL_HIGH, 8'h00);
    wr(ADDR_DWELL_LOW, 8'h02);
    wr(ADDR_UP_LOW, 8'h64);
    wr(ADDR_UP_HIGH, 8'h01);
    wr(ADDR_LO_LOW, 8'h32);
    wr(ADDR_IRQ_MASK, 8'h01);
    smp(13'h012C, 1);
    hold(1'b0);
    smp(13'h0190, 1);
    hold(1'b1);
    repeat (3) @(posedge mclk);
    #1 chk("irq", {7'h00, irq}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h0F);
    repeat (2) @(posedge mclk);
    #1 chk("irq", {7'h00, irq}, 8'h00);
    smp(13'h000A, 2);
    hold(1'b1);
    smp(13'h003C, 1);
    smp(13'h000A, 2);
    hold(1'b1);
    smp(13'h000A, 1);
    hold(1'b0);
    rd(ADDR_IRQ_STATUS, 8'h02, "irq_status");
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_PERIOD_B2, 8'h00);
    wr(ADDR_PERIOD_B1, 8'h00);
    wr(ADDR_PERIOD_B0, 8'h04);
    wr(ADDR_MON_CTRL, 8'h02);
    smp(13'h012C, 12);
    rd(ADDR_PEAK_LOW, 8'h2C, "peak_low");
    rd(ADDR_PEAK_HIGH, 8'h01, "peak_high");
    smp(13'h0064, 12);
    rd(ADDR_PEAK_LOW, 8'h64, "peak_low");
    rd(ADDR_PEAK_HIGH, 8'h00, "peak_high");
    // period expiry keeps status bit 2 busy; bit 3 shows whether a realignment took place
    wr(ADDR_SYNC_CTRL, 8'h03);
    wr(ADDR_IRQ_STATUS, 8'h0F);
    pulse();
    rd(ADDR_SYNC_CTRL, 8'h02, "sync_ctrl");
    rd(ADDR_IRQ_STATUS, 8'h0C, "irq_status");
    wr(ADDR_IRQ_STATUS, 8'h0F);
    pulse();
    rd(ADDR_IRQ_STATUS, 8'h04, "irq_status");
    wr(ADDR_SYNC_CTRL, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h0F);
    pulse();
    rd(ADDR_SYNC_CTRL, 8'h01, "sync_ctrl");
    rd(ADDR_IRQ_STATUS, 8'h0C, "irq_status");
    wr(ADDR_IRQ_STATUS, 8'h0F);
    pulse();
    rd(ADDR_IRQ_STATUS, 8'h0C, "irq_status");
    wr(ADDR_SYNC_CTRL, 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h0F);
    pulse();
    rd(ADDR_SYNC_CTRL, 8'h02, "sync_ctrl");
    rd(ADDR_IRQ_STATUS, 8'h04, "irq_status");
    finish_test();
  end
endmodule // tb
